/* rtl/ppwm_params.svh */
// Register offsets, field positions, reset values and counts of the pulse block
`ifndef PPWM_PARAMS_SVH
`define PPWM_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PPWM_CTRL0 7'h00
`define PPWM_CTRL1 7'h04
`define PPWM_PCON0 7'h08
`define PPWM_PCON1 7'h0c
`define PPWM_DEAD_TIME_CONTROL 7'h10
`define PPWM_OVSEL 7'h14
`define PPWM_OVST 7'h18
`define PPWM_FLTCFG 7'h1c
`define PPWM_CNT_L 7'h20
`define PPWM_CNT_H 7'h24
`define PPWM_PER_L 7'h28
`define PPWM_PER_H 7'h2c
`define PPWM_EVT_L 7'h30
`define PPWM_EVT_H 7'h34
`define PPWM_DUTY_L0 7'h38
`define PPWM_DUTY_STEP 7'h08
`define PPWM_HIGH_OFS 7'h04
`define PPWM_STAT 7'h58

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PPWM_EN_BIT 7
`define PPWM_POST_MSB 7
`define PPWM_POST_LSB 4
`define PPWM_PSC_MSB 3
`define PPWM_PSC_LSB 2
`define PPWM_MODE_MSB 1
`define PPWM_MODE_LSB 0
`define PPWM_DBGOFF_BIT 0

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define PPWM_PER_RST 16'h00ff
`define PPWM_PSC_LAST0 8'h03
`define PPWM_PSC_LAST1 8'h0f
`define PPWM_PSC_LAST2 8'h3f
`define PPWM_PSC_LAST3 8'hff

`endif

/* rtl/ppwm_pkg.sv */
// Types shared by the pulse block
package ppwm_pkg;
	typedef enum logic [1:0] {
		PPWM_FREE = 2'b00,
		PPWM_SINGLE = 2'b01,
		PPWM_UPDN = 2'b10,
		PPWM_UPDN2 = 2'b11
	} ppwm_mode_t;

	typedef struct packed {
		logic [7:0] ctrl0;
		logic [7:0] ctrl1;
		logic [7:0] pcon0;
		logic [7:0] pcon1;
		logic [7:0] dead_time_control;
		logic [7:0] ovsel;
		logic [7:0] ovst;
		logic [7:0] fltcfg;
		logic [15:0] cnt_buf;
		logic [15:0] per_buf;
		logic [15:0] evt_buf;
		logic [15:0] per;
		logic [15:0] evt;
		logic [3:0][15:0] duty_buf;
		logic [3:0][15:0] duty;
		logic cload;
		logic dir;
		logic dbg;
		logic upd_evt;
		logic trig;
		logic waitreq;
		logic [11:0] count;
		logic [7:0] div;
		logic [3:0] post;
		logic [3:0] raw;
		logic [3:0][7:0] dt;
		logic [7:0] out;
		logic [31:0] rdata;
	} ppwm_state_t;
endpackage

/* rtl/ppwm_top.sv */
// Power pulse generator: time base, duty compare, dead time, Avalon slave
`timescale 1ns/1ps
`default_nettype none
`include "ppwm_params.svh"

module ppwm_top (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [6:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic debug_mode,
	output logic [7:0] pulse_out,
	output logic update_event,
	output logic event_trigger
);
	// ----------------------------------------
	// Helper functions
	// ----------------------------------------

	// Last divider value of one time-base tick
	function automatic logic [7:0] psc_last(input logic [1:0] ps);
		logic [7:0] r;
		r = `PPWM_PSC_LAST0;
		case (ps)
			2'h1: r = `PPWM_PSC_LAST1;
			2'h2: r = `PPWM_PSC_LAST2;
			2'h3: r = `PPWM_PSC_LAST3;
			default: r = `PPWM_PSC_LAST0;
		endcase
		return r;
	endfunction

	// Quarter of the tick that the divider is in
	function automatic logic [1:0] phase(input logic [7:0] d, input logic [1:0] ps);
		logic [1:0] r;
		r = d[1:0];
		case (ps)
			2'h1: r = d[3:2];
			2'h2: r = d[5:4];
			2'h3: r = d[7:6];
			default: r = d[1:0];
		endcase
		return r;
	endfunction

	// Register read decode, byte wide
	function automatic logic [7:0] reg_read(input ppwm_pkg::ppwm_state_t v,
			input logic [6:0] a);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			`PPWM_CTRL0: r = v.ctrl0;
			`PPWM_CTRL1: r = v.ctrl1;
			`PPWM_PCON0: r = v.pcon0;
			`PPWM_PCON1: r = v.pcon1;
			`PPWM_DEAD_TIME_CONTROL: r = v.dead_time_control;
			`PPWM_OVSEL: r = v.ovsel;
			`PPWM_OVST: r = v.ovst;
			`PPWM_FLTCFG: r = v.fltcfg;
			`PPWM_CNT_L: r = v.count[7:0];
			`PPWM_CNT_H: r = {4'h0, v.count[11:8]};
			`PPWM_PER_L: r = v.per_buf[7:0];
			`PPWM_PER_H: r = v.per_buf[15:8];
			`PPWM_EVT_L: r = v.evt_buf[7:0];
			`PPWM_EVT_H: r = v.evt_buf[15:8];
			`PPWM_STAT: r = {3'h0, v.dir, v.post};
			default: r = 8'h00;
		endcase
		for (int p = 0; p < 4; p++) begin
			if (a == 7'(`PPWM_DUTY_L0 + p * `PPWM_DUTY_STEP)) begin
				r = v.duty_buf[p][7:0];
			end
			if (a == 7'(`PPWM_DUTY_L0 + p * `PPWM_DUTY_STEP + `PPWM_HIGH_OFS)) begin
				r = v.duty_buf[p][15:8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// State and next state
	// ----------------------------------------
	ppwm_pkg::ppwm_state_t s;
	ppwm_pkg::ppwm_state_t n;
	ppwm_pkg::ppwm_mode_t mode;
	logic tick;
	logic bnd;
	logic wr_now;
	logic [1:0] psc;
	logic [13:0] cmp;
	logic [7:0] wb;

	assign mode = ppwm_pkg::ppwm_mode_t'(s.ctrl0[`PPWM_MODE_MSB:`PPWM_MODE_LSB]);
	assign psc = s.ctrl0[`PPWM_PSC_MSB:`PPWM_PSC_LSB];
	// A write lands only at the edge where waitrequest is seen low
	assign wr_now = write & ~s.waitreq & byteenable[0];
	assign wb = writedata[7:0];
	assign tick = (s.div == psc_last(psc));
	// Fine compare: counter plus the quarter of the current tick
	assign cmp = {s.count, phase(s.div, psc)};

	// Next-state logic for the whole block
	always_comb begin
		n = s;
		bnd = 1'b0;
		n.upd_evt = 1'b0;
		n.trig = 1'b0;
		// Prescaler runs free so the tick phase stays steady
		n.div = tick ? 8'h00 : s.div + 8'h01;

		// Time base stepping, only while enabled
		if (s.ctrl1[`PPWM_EN_BIT] && tick) begin
			n.trig = (s.count == s.evt[11:0]);
			unique case (mode)
				ppwm_pkg::PPWM_FREE,
				ppwm_pkg::PPWM_SINGLE: begin
					if (s.count >= s.per[11:0]) begin
						n.count = 12'h000;
						bnd = 1'b1;
						if (mode == ppwm_pkg::PPWM_SINGLE) begin
							// One period then stop, software rearms
							n.ctrl1[`PPWM_EN_BIT] = 1'b0;
						end
					end else begin
						n.count = s.count + 12'h001;
					end
				end
				ppwm_pkg::PPWM_UPDN,
				ppwm_pkg::PPWM_UPDN2: begin
					// Up then down gives pulses centred on zero
					if (s.dir) begin
						if (s.count >= s.per[11:0]) begin
							n.dir = 1'b0;
							if (s.count != 12'h000) begin
								n.count = s.count - 12'h001;
							end
							// Second update point at the top
							bnd = (mode == ppwm_pkg::PPWM_UPDN2);
						end else begin
							n.count = s.count + 12'h001;
						end
					end else begin
						if (s.count == 12'h000) begin
							n.dir = 1'b1;
							if (s.per[11:0] != 12'h000) begin
								n.count = 12'h001;
							end
							bnd = 1'b1;
						end else begin
							n.count = s.count - 12'h001;
						end
					end
				end
			endcase
		end

		// Postscaler: one update event per N+1 boundaries
		if (bnd) begin
			if (s.post == s.ctrl0[`PPWM_POST_MSB:`PPWM_POST_LSB]) begin
				n.post = 4'h0;
				n.upd_evt = 1'b1;
			end else begin
				n.post = s.post + 4'h1;
			end
		end

		// Buffers reach the active values at an update or while stopped
		if (n.upd_evt || !s.ctrl1[`PPWM_EN_BIT]) begin
			n.per = s.per_buf;
			n.evt = s.evt_buf;
			n.duty = s.duty_buf;
		end
		// A pending count load only while stopped or at an update
		if (s.cload && (n.upd_evt || !s.ctrl1[`PPWM_EN_BIT])) begin
			n.count = s.cnt_buf[11:0];
			n.cload = 1'b0;
		end

		// Duty compare, dead time and output shaping per pair
		n.dbg = debug_mode & s.pcon1[`PPWM_DBGOFF_BIT];
		for (int p = 0; p < 4; p++) begin
			n.raw[p] = (s.duty[p][13:0] > cmp);
			if (s.pcon0[p] && (n.raw[p] != s.raw[p])) begin
				n.dt[p] = s.dead_time_control;
			end else if (s.dt[p] != 8'h00) begin
				n.dt[p] = s.dt[p] - 8'h01;
			end
			if (n.dbg) begin
				n.out[2*p +: 2] = 2'b00;
			end else if (!s.pcon0[p]) begin
				n.out[2*p +: 2] = {n.raw[p], n.raw[p]};
			end else if (n.dt[p] != 8'h00) begin
				// Both switches off while the other one drains
				n.out[2*p +: 2] = 2'b00;
			end else begin
				n.out[2*p +: 2] = {n.raw[p], ~n.raw[p]};
			end
		end

		// Bus answer: one wait cycle, then waitrequest low for one cycle
		n.waitreq = 1'b1;
		if ((read || write) && s.waitreq) begin
			n.waitreq = 1'b0;
			n.rdata = read ? {24'h000000, reg_read(s, address)} : 32'h00000000;
		end

		// Register writes, after hardware so a set by software wins
		if (wr_now) begin
			case (address)
				`PPWM_CTRL0: n.ctrl0 = wb;
				`PPWM_CTRL1: n.ctrl1 = wb;
				`PPWM_PCON0: n.pcon0 = wb;
				`PPWM_PCON1: n.pcon1 = wb;
				`PPWM_DEAD_TIME_CONTROL: n.dead_time_control = wb;
				`PPWM_OVSEL: n.ovsel = wb;
				`PPWM_OVST: n.ovst = wb;
				`PPWM_FLTCFG: n.fltcfg = wb;
				`PPWM_CNT_L: begin
					n.cnt_buf[7:0] = wb;
					n.cload = 1'b1;
				end
				`PPWM_CNT_H: begin
					n.cnt_buf[15:8] = wb;
					n.cload = 1'b1;
				end
				`PPWM_PER_L: n.per_buf[7:0] = wb;
				`PPWM_PER_H: n.per_buf[15:8] = wb;
				`PPWM_EVT_L: n.evt_buf[7:0] = wb;
				`PPWM_EVT_H: n.evt_buf[15:8] = wb;
				default: n.cload = n.cload;
			endcase
			for (int p = 0; p < 4; p++) begin
				if (address == 7'(`PPWM_DUTY_L0 + p * `PPWM_DUTY_STEP)) begin
					n.duty_buf[p][7:0] = wb;
				end
				if (address == 7'(`PPWM_DUTY_L0 + p * `PPWM_DUTY_STEP + `PPWM_HIGH_OFS)) begin
					n.duty_buf[p][15:8] = wb;
				end
			end
		end
	end

	// State register with synchronous reset
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s <= '0;
			s.waitreq <= 1'b1;
			s.per <= `PPWM_PER_RST;
			s.per_buf <= `PPWM_PER_RST;
			s.dir <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from the state register
	assign readdata = s.rdata;
	assign waitrequest = s.waitreq;
	assign pulse_out = s.out;
	assign update_event = s.upd_evt;
	assign event_trigger = s.trig;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// Free-running wrap at the period
	a_free_wrap: assert property (
			s.ctrl1[`PPWM_EN_BIT] && tick && mode == ppwm_pkg::PPWM_FREE
			&& s.count >= s.per[11:0] && !s.cload |=> s.count == 12'h000)
		else $error("free-run count did not wrap");

	// Single shot stops itself
	a_single_stop: assert property (
			s.ctrl1[`PPWM_EN_BIT] && tick && mode == ppwm_pkg::PPWM_SINGLE
			&& s.count >= s.per[11:0] && !wr_now |=> !s.ctrl1[`PPWM_EN_BIT])
		else $error("single shot kept running");

	// Stopped counter keeps its value
	a_hold_count: assert property (
			!s.ctrl1[`PPWM_EN_BIT] && !s.cload && !wr_now |=> $stable(s.count))
		else $error("count moved while stopped");

	// Up/down turns at the period
	sequence top_reached;
		s.ctrl1[`PPWM_EN_BIT] && tick && s.dir && mode[1] && s.count >= s.per[11:0] && !s.cload;
	endsequence
	a_updn_turn: assert property (
			top_reached |=> !s.dir ##0 (mode != ppwm_pkg::PPWM_UPDN2
			|| s.post != $past(s.post) || s.upd_evt))
		else $error("up/down count did not turn");

	// Postscaler fires on the selected boundary
	a_post_ratio: assert property (
			bnd && s.post == s.ctrl0[`PPWM_POST_MSB:`PPWM_POST_LSB]
			|=> s.upd_evt && s.post == 4'h0)
		else $error("postscale event missing");

	// Trigger on event compare match
	a_evt_trig: assert property (
			s.ctrl1[`PPWM_EN_BIT] && tick && s.count == s.evt[11:0] |=> s.trig)
		else $error("event trigger missing");

	// Dead time keeps both of a pair low; outputs lag the pair mode by a cycle
	a_dead_off: assert property (
			$past(s.pcon0[0]) && s.dt[0] != 8'h00 |-> s.out[1:0] == 2'b00)
		else $error("pair driven during dead time");

	// Each compare change of a complementary pair restarts the dead time
	a_dead_load: assert property (
			$past(s.pcon0[0]) && s.raw[0] != $past(s.raw[0]) |-> s.dt[0] == $past(s.dead_time_control))
		else $error("dead time not restarted");

	// Complementary pair outside dead time
	a_comp_pair: assert property (
			$past(s.pcon0[0]) && s.dt[0] == 8'h00 && !s.dbg |-> s.out[0] == !s.out[1])
		else $error("pair not complementary");

	// Debug disable forces all outputs low
	a_debug_off: assert property (
			debug_mode && s.pcon1[`PPWM_DBGOFF_BIT] |=> s.out == 8'h00)
		else $error("outputs active in debug");

	// Buffered period only lands at update or stop
	a_buf_period: assert property (
			s.per != $past(s.per) |-> s.upd_evt || !$past(s.ctrl1[`PPWM_EN_BIT]))
		else $error("period changed outside update");

	// Bus answers after one wait cycle
	a_bus_answer: assert property (
			(read || write) && s.waitreq |=> !s.waitreq ##1 s.waitreq)
		else $error("bus answer timing wrong");
endmodule
`default_nettype wire

/* testbench/ppwm_bridge_model.sv */
// Half-bridge switch model that sits on the pulse outputs
`timescale 1ns/1ps
`default_nettype none

module ppwm_bridge_model (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] pulse_out,
	output logic [3:0] phase,
	output logic [15:0] shoot_cnt
);
	// -------------------------------------------------------------
	// Leg state: odd switch pulls the node up, even pulls it down
	// -------------------------------------------------------------
	// A floating node toggles so that a stale level is never trusted
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			phase <= 4'h0;
			shoot_cnt <= 16'h0;
		end else begin
			for (int p = 0; p < 4; p++) begin
				if (pulse_out[2*p+1] && pulse_out[2*p]) begin
					shoot_cnt <= shoot_cnt + 16'h1;
				end
				if (pulse_out[2*p+1]) begin
					phase[p] <= 1'b1;
				end else if (pulse_out[2*p]) begin
					phase[p] <= 1'b0;
				end else begin
					phase[p] <= ~phase[p];
				end
			end
		end
	end
endmodule

`default_nettype wire

/* testbench/test_power_pwm_time_base.sv */
// Self-checking bench for the power pulse block
`timescale 1ns/1ps
`default_nettype none
`include "ppwm_params.svh"

module test_power_pwm_time_base;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [6:0] address = 7'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] writedata = 32'h0;
	logic debug_mode = 1'b0;
	logic [31:0] readdata;
	logic waitrequest;
	logic [7:0] pulse_out;
	logic update_event;
	logic event_trigger;
	logic [3:0] phase;
	logic [15:0] shoot_cnt;
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;
	integer seed = 32'h0f17a24e;
	logic [31:0] rd;
	logic [7:0] d;
	logic [7:0] orv;
	logic [1:0] m;
	logic [3:0] post;
	logic [1:0] ck;
	logic [15:0] sc0;
	int gap, h0, h1, zz, c01, c10, trg;

	// -------------------------------------------------------------
	// Clock, design, far side
	// -------------------------------------------------------------
	always #50 mclk = ~mclk;

	ppwm_top dut (.mclk(mclk), .nrst(nrst), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .debug_mode(debug_mode), .pulse_out(pulse_out),
		.update_event(update_event), .event_trigger(event_trigger));

	ppwm_bridge_model bridge (.mclk(mclk), .nrst(nrst), .pulse_out(pulse_out), .phase(phase),
		.shoot_cnt(shoot_cnt));

	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	// One Avalon access; held until waitrequest is sampled low
	task automatic bus(input logic rw, input logic [6:0] a, input logic [7:0] dat);
		@(posedge mclk);
		address <= a;
		writedata <= {24'h0, dat};
		byteenable <= 4'hf;
		write <= rw;
		read <= !rw;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] dat);
		bus(1'b1, a, dat);
	endtask

	task automatic rdx(input logic [6:0] a);
		bus(1'b0, a, 8'h00);
	endtask

	// Stop, rewind the count, set mode and postscale, start again
	task automatic run(input logic [1:0] md, input logic [3:0] ps, input logic [1:0] ck);
		wr(`PPWM_CTRL1, 8'h00);
		wr(`PPWM_CNT_L, 8'h00);
		wr(`PPWM_CNT_H, 8'h00);
		wr(`PPWM_CTRL0, {ps, ck, md});
		wr(`PPWM_CTRL1, 8'h80);
	endtask

	// Cycles between two update pulses
	task automatic measure();
		do @(posedge mclk); while (update_event !== 1'b1);
		gap = 0;
		do begin
			@(posedge mclk);
			gap++;
		end while (update_event !== 1'b1);
	endtask

	// Tally output patterns over a window
	task automatic watch(input int n);
		h0 = 0; h1 = 0; zz = 0; c01 = 0; c10 = 0; trg = 0;
		orv = 8'h00;
		repeat (n) begin
			@(posedge mclk);
			h0 += pulse_out[0];
			h1 += pulse_out[1];
			zz += (pulse_out[1:0] == 2'b00);
			c01 += (pulse_out[1:0] == 2'b01);
			c10 += (pulse_out[1:0] == 2'b10);
			trg += event_trigger;
			orv |= pulse_out;
		end
	endtask

	// Ticks per boundary times prescale 4/16/64/256 times postscale ratio
	function automatic int exp_gap(input logic [1:0] md, input int per, input int n,
			input logic [1:0] ck);
		int ticks;
		ticks = (md == 2'b10) ? 2 * per : (md == 2'b11) ? per : per + 1;
		return ticks * (4 << (2 * int'(ck))) * (n + 1);
	endfunction

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Hang guard, well above the few thousand cycles needed
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end

	// -------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------
	initial begin
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		rdx(`PPWM_PER_L);
		check(rd, 32'hff);
		rdx(`PPWM_CTRL0);
		check(rd, 32'h00);
		wr(7'h5c, 8'h5a);
		rdx(7'h5c);
		check(rd, 32'h00);
		done("reset");
		// Random readback, then clear so overrides stay quiet
		for (int o = 8; o < 88; o += 4) begin
			if (o < 32 || o > 44) begin
				d = 8'($random(seed));
				wr(7'(o), d);
				rdx(7'(o));
				check(rd, {24'h0, d});
				wr(7'(o), 8'h00);
			end
		end
		done("registers");
		// Slow prescales first, so later fixed waits see a settled divider
		wr(`PPWM_PER_L, 8'h07);
		for (int k = 0; k < 7; k++) begin
			m = (k == 4) ? 2'b10 : (k == 5) ? 2'b11 : 2'b00;
			post = (k == 6) ? 4'hf : (k < 3) ? 4'h0 : 4'($random(seed) & 3);
			ck = (k < 3) ? 2'(k + 1) : 2'b00;
			run(m, post, ck);
			measure();
			check(gap, exp_gap(m, 7, int'(post), ck));
		end
		done("time base");
		// Stopping holds the count
		wr(`PPWM_CTRL1, 8'h00);
		rdx(`PPWM_CNT_L);
		d = rd[7:0];
		repeat (40) @(posedge mclk);
		rdx(`PPWM_CNT_L);
		check(rd, {24'h0, d});
		done("hold");
		// Single shot stops itself after one period
		run(2'b01, 4'h0, 2'b00);
		repeat (80) @(posedge mclk);
		rdx(`PPWM_CTRL1);
		check(rd, 32'h00);
		done("single");
		// Independent pair: 10 of 32 quarter steps high, after the restart period
		wr(`PPWM_DUTY_L0, 8'h0a);
		run(2'b00, 4'h0, 2'b00);
		repeat (64) @(posedge mclk);
		watch(32);
		check(h1, 10);
		check(h0, 10);
		check(trg, 1);
		done("duty");
		// Complementary pair with 3 cycles of dead time
		wr(`PPWM_DEAD_TIME_CONTROL, 8'h03);
		wr(`PPWM_PCON0, 8'h01);
		repeat (64) @(posedge mclk);
		sc0 = shoot_cnt;
		watch(64);
		check(zz, 12);
		check((c01 > 0) && (c10 > 0), 1);
		check(16'(shoot_cnt - sc0), 16'h0);
		done("dead time");
		// Debug disable forces every output off
		debug_mode <= 1'b1;
		wr(`PPWM_PCON1, 8'h01);
		repeat (2) @(posedge mclk);
		watch(40);
		check(orv, 8'h00);
		debug_mode <= 1'b0;
		done("debug");
		report_and_stop();
	end
endmodule

`default_nettype wire
